// ==== rtl/sacc_pkg.sv ====
// Constants, types and register map of the serial accumulator execution block
`default_nettype none
package sacc_pkg;
	localparam int WORD_BITS = 32;
	localparam logic [4:0] SIGN_BIT = 5'h1f;
	localparam int LONG_WORDS_DEF = 8;
	localparam logic [1:0] OP_INPUT = 2'h1;
	localparam logic [1:0] OP_SWAP = 2'h2;
	localparam logic [1:0] OP_DIV = 2'h3;
	localparam logic [6:0] WP_FIRST = 7'h01;
	localparam logic [6:0] WP_ODD0 = 7'h03;
	localparam logic [6:0] WP_EVEN0 = 7'h04;
	localparam logic [6:0] WP_SECTOR = 7'h40;
	localparam logic [6:0] WP_LAST_ODD = 7'h41;
	localparam logic [6:0] WP_RESTORE = 7'h42;
	localparam logic [6:0] WP_QUOT = 7'h43;
	localparam logic [2:0] FGH_WP1 = 3'h6;
	localparam logic [2:0] FGH_WP2 = 3'h1;
	localparam logic [2:0] FGH_WP4 = 3'h5;
	localparam logic [2:0] FGH_WP65 = 3'h7;
	localparam logic [2:0] FGH_WP66 = 3'h3;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_UPPER = 8'h08;
	localparam logic [7:0] OFS_LOWER = 8'h0c;
	localparam logic [7:0] OFS_INDEX = 8'h10;
	localparam logic [7:0] OFS_OPERAND = 8'h14;
	localparam logic [7:0] OFS_CHARS = 8'h18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {S_IDLE, S_ALIGN, S_EXEC, S_SEARCH, S_SWAP, S_DIV} state_e;
	typedef struct packed {
		logic track_hi;
		logic [5:0] trk;
		logic rpt;
		logic [1:0] op;
	} ctrl_s;
	typedef struct packed {
		logic [5:0] chr;
		logic [2:0] fgh;
		logic k;
		logic p1;
		logic hold;
		logic m;
		logic n;
		logic busy;
	} status_s;
endpackage
`default_nettype wire

// ==== rtl/serial_accumulator_exec.sv ====
// Bit-serial accumulator datapath: character input, swap and single divide
// What this block does
// RULE1: Input execute starts after next sign time, or at eight-word pulse when long.
// RULE2: One-word mode couples lower and upper as a two-word line.
// RULE3: High track flag inserts all six character bits.
// RULE4: First input cycle recirculates; later cycles put six shift stages in loop. The code puts only four in the loop when the high track flag is clear.
// RULE5: During search each accumulator recirculates on its own.
// RULE6: High track flag clear feeds stage four from lower line.
// RULE7: Eight-word mode: stages tap long line, lower fed from last stage.
// RULE8: Unlimited characters accepted; overflow lost when stages reload.
// RULE9: Start switch or stop code ends input in search, clearing hold flag.
// RULE10: Swap track bit 1 copies upper into lower, else lower recirculates.
// RULE11: Track bits 2 and 8 load upper from lower and index, ORed.
// RULE12: Track bit 4 copies upper to index only when not repeating.
// RULE13: Track 16 sets long, 32 sets short, both toggle, at sign time.
// RULE14: Single divide: non-restoring, quotient to upper, remainder to lower.
// RULE15: Word period 1 loads divisor and latches divisor and dividend signs.
// RULE16: Odd periods take remainder sign as quotient bit and shift remainder.
// RULE17: Odd/even flag set in period 1, cleared at sign of period 3.
// RULE18: Phase flags identify divide word period groups.
// RULE19: Even periods subtract divisor if signs agree, else add.
// RULE20: Sector coincidence at period 64 sets carry, three more periods follow.
// RULE21: Period 66 restores remainder by last digit into lower.
// RULE22: Period 67 writes quotient, complemented or incremented by divisor sign.
// RULE23: Every update on the bit clock; sign time is bit 31.
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`default_nettype none
module serial_accumulator_exec
	import sacc_pkg::*;
#(
	parameter int LONG_WORDS = LONG_WORDS_DEF
)(
	input wire logic aclk, // Bit clock
	input wire logic aresetn, // Sync reset
	input wire logic [7:0] awaddr, // Write address
	input wire logic [2:0] awprot, // Unused protection
	input wire logic awvalid, // Write address valid
	output logic awready, // Write address ready
	input wire logic [31:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Byte enables
	input wire logic wvalid, // Write data valid
	output logic wready, // Write data ready
	output logic [1:0] bresp, // Write response
	output logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	input wire logic [7:0] araddr, // Read address
	input wire logic [2:0] arprot, // Unused protection
	input wire logic arvalid, // Read address valid
	output logic arready, // Read address ready
	output logic [31:0] rdata, // Read data
	output logic [1:0] rresp, // Read response
	output logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	input wire logic char_valid, // Character present
	input wire logic [5:0] char_data, // Presented character
	output logic char_taken, // Character accepted pulse
	input wire logic stop_code, // Stop code from unit
	input wire logic operator_go_switch, // Panel switch, async
	output logic input_call, // Request for input
	output logic busy // Command running
);
	localparam int LEN = WORD_BITS * LONG_WORDS;
	localparam int WB = $clog2(LONG_WORDS);

	if (LONG_WORDS < 2 || LONG_WORDS > 64 || (LONG_WORDS & (LONG_WORDS - 1)) != 0)
		$error("LONG_WORDS must be a power of two from 2 to 64");

	state_e state_r;
	ctrl_s ctrl_r;
	status_s stat;
	logic [4:0] bit_r;
	logic [WB-1:0] wcnt_r;
	logic [6:0] wp_r;
	logic [31:0] u_r, x_r, v_r, q_r, cnt_r;
	logic [LEN-1:0] l_r;
	logic [5:0] p_r;
	logic n_r, m_r, a_r, p1_r, k_r, stop_r;
	logic go_s1_r, go_s2_r, go_s3_r;
	logic bvalid_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic char_taken_r;
	logic sign_t, t8, exec_end, rot, go_rise, stop_now, take_char;
	logic u_in, l_in, x_in;
	logic wr_fire, rd_fire, go, idle;
	logic div_odd, div_even, div_t;
	logic [31:0] addsub, restore, quot;
	logic [2:0] fgh;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[8*i+:8] = d[8*i+:8];
		return r;
	endfunction

	assign idle = state_r == S_IDLE;
	assign sign_t = bit_r == SIGN_BIT; // RULE23
	assign t8 = sign_t && wcnt_r == WB'(LONG_WORDS - 1);
	assign exec_end = sign_t && wp_r == (n_r ? 7'(LONG_WORDS - 1) : 7'h01);
	assign rot = state_r inside {S_ALIGN, S_EXEC, S_SEARCH, S_SWAP};
	assign go_rise = go_s2_r && !go_s3_r;
	assign stop_now = stop_r || stop_code || go_rise;
	assign take_char = state_r == S_SEARCH && sign_t && !stop_now && char_valid;

	// Bit and sector timing
	always_ff @(posedge aclk)
	begin
		if (!aresetn || idle)
		begin
			bit_r <= '0;
			wcnt_r <= '0;
		end
		else
		begin
			bit_r <= bit_r + 5'h01; // RULE23
			if (sign_t)
				wcnt_r <= wcnt_r + WB'(1);
		end
	end

	// Panel switch synchroniser
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			go_s1_r <= 1'b0;
			go_s2_r <= 1'b0;
			go_s3_r <= 1'b0;
		end
		else
		begin
			go_s1_r <= operator_go_switch;
			go_s2_r <= go_s1_r;
			go_s3_r <= go_s2_r;
		end
	end

	// Command sequencing
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= S_IDLE;
			wp_r <= '0;
			m_r <= 1'b0;
			a_r <= 1'b0;
		end
		else
		begin
			unique case (state_r)
				S_IDLE:
					if (go)
					begin
						m_r <= 1'b0;
						wp_r <= (wdata[1:0] == OP_DIV) ? WP_FIRST : 7'h00;
						state_r <= (wdata[1:0] == OP_INPUT) ? S_ALIGN : (wdata[1:0] == OP_SWAP) ? S_SWAP : S_DIV;
					end
				S_ALIGN:
					if (sign_t && (!n_r || t8)) // RULE1
					begin
						state_r <= S_EXEC;
						wp_r <= '0;
					end
				S_EXEC:
					if (sign_t)
					begin
						wp_r <= wp_r + 7'h01;
						if (exec_end)
						begin
							state_r <= S_SEARCH;
							a_r <= 1'b1;
						end
					end
				S_SEARCH:
					if (sign_t && stop_now)
					begin
						state_r <= S_IDLE; // RULE9
						a_r <= 1'b0; // RULE9
					end
					else if (take_char)
					begin
						m_r <= 1'b1;
						state_r <= S_ALIGN;
					end
				S_SWAP:
					if (sign_t)
						state_r <= S_IDLE;
				S_DIV:
					if (sign_t)
					begin
						wp_r <= wp_r + 7'h01;
						if (wp_r == WP_QUOT)
							state_r <= S_IDLE;
					end
				default:
					state_r <= S_IDLE;
			endcase
		end
	end

	// Stop request held until the next sign time
	always_ff @(posedge aclk)
	begin
		if (!aresetn || state_r != S_SEARCH)
			stop_r <= 1'b0;
		else if (stop_code || go_rise)
			stop_r <= 1'b1;
	end

	// Serial inputs of the three lines
	always_comb
	begin
		u_in = u_r[0];
		l_in = l_r[0];
		x_in = x_r[0];
		unique case (state_r)
			S_EXEC:
				if (!n_r)
				begin
					u_in = m_r ? p_r[0] : l_r[0]; // RULE2 RULE4
					l_in = u_r[0]; // RULE2
				end
				else
					l_in = m_r ? p_r[0] : l_r[0]; // RULE7
			S_SWAP:
			begin
				l_in = ctrl_r.trk[0] ? u_r[0] : l_r[0]; // RULE10
				if (ctrl_r.trk[1] || ctrl_r.trk[3])
					u_in = (ctrl_r.trk[1] & l_r[0]) | (ctrl_r.trk[3] & x_r[0]); // RULE11
				x_in = (ctrl_r.trk[2] && !ctrl_r.rpt) ? u_r[0] : x_r[0]; // RULE12
			end
			default:
			begin
			end
		endcase
	end

	// Divide arithmetic
	assign div_t = state_r == S_DIV && sign_t;
	assign div_odd = wp_r >= WP_ODD0 && wp_r <= WP_LAST_ODD && p1_r; // RULE16
	assign div_even = wp_r >= WP_EVEN0 && wp_r <= WP_SECTOR && !p1_r;
	assign addsub = (p_r[1] == p_r[0]) ? u_r - l_r[31:0] : u_r + l_r[31:0]; // RULE19
	assign restore = p_r[1] ? u_r - l_r[31:0] : u_r + l_r[31:0]; // RULE21
	// Negative divisor flips the sign digit, positive keeps it; the low digit folds in the restoring step
	assign quot = p_r[1] ? {~q_r[31], q_r[30:1], 1'b1} + {31'h00000000, q_r[0]} : {q_r[31], ~q_r[30:0]}; // RULE22

	always_comb
	begin
		if (state_r != S_DIV)
			fgh = 3'h0;
		else if (wp_r == WP_FIRST)
			fgh = FGH_WP1; // RULE18
		else if (wp_r < WP_EVEN0)
			fgh = FGH_WP2;
		else if (wp_r <= WP_SECTOR)
			fgh = FGH_WP4;
		else if (wp_r == WP_LAST_ODD)
			fgh = FGH_WP65;
		else
			fgh = FGH_WP66;
	end

	// Upper accumulator
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			u_r <= '0;
		else if (idle)
		begin
			if (wr_fire && awaddr == OFS_UPPER)
				u_r <= merge(u_r, wdata, wstrb);
		end
		else if (rot)
			u_r <= {u_in, u_r[31:1]}; // RULE5
		else if (div_t)
		begin
			if (div_odd)
			begin
				// Last odd period keeps the remainder for restoring
				if (wp_r != WP_LAST_ODD)
					u_r <= {u_r[30:0], 1'b0}; // RULE16
			end
			else if (div_even)
				u_r <= addsub; // RULE14 RULE19
			else if (wp_r == WP_QUOT)
				u_r <= quot; // RULE22
		end
	end

	// Lower accumulator, one word or long line
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			l_r <= '0;
		else if (idle)
		begin
			if (wr_fire && awaddr == OFS_LOWER)
				l_r[31:0] <= merge(l_r[31:0], wdata, wstrb);
		end
		else if (rot)
		begin
			// Long line moves only while executing, so word 0 stays aligned
			if (n_r && state_r == S_EXEC)
				l_r <= {l_in, l_r[LEN-1:1]}; // RULE7
			else
				l_r[31:0] <= {l_in, l_r[31:1]}; // RULE5
		end
		else if (div_t && wp_r == WP_FIRST)
			l_r[31:0] <= v_r; // RULE15
		else if (div_t && wp_r == WP_RESTORE)
			l_r[31:0] <= p_r[0] ? restore : u_r; // RULE21
	end

	// Index register and operand
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			x_r <= '0;
		else if (idle && wr_fire && awaddr == OFS_INDEX)
			x_r <= merge(x_r, wdata, wstrb);
		else if (state_r == S_SWAP)
			x_r <= {x_in, x_r[31:1]}; // RULE12
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			v_r <= '0;
		else if (idle && wr_fire && awaddr == OFS_OPERAND)
			v_r <= merge(v_r, wdata, wstrb);
	end

	// Line length flag
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			n_r <= 1'b0;
		else if (state_r == S_SWAP && sign_t)
		begin
			if (ctrl_r.trk[4] && ctrl_r.trk[5])
				n_r <= !n_r; // RULE13
			else if (ctrl_r.trk[4])
				n_r <= 1'b1; // RULE13
			else if (ctrl_r.trk[5])
				n_r <= 1'b0; // RULE13
		end
	end

	// Character shift stages, also divide sign flags
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			p_r <= '0;
		else if (state_r == S_EXEC)
		begin
			p_r[5] <= l_r[0];
			p_r[4] <= p_r[5];
			p_r[3] <= ctrl_r.track_hi ? p_r[4] : l_r[0]; // RULE3 RULE6
			p_r[2:0] <= p_r[3:1];
		end
		else if (take_char)
			p_r <= char_data; // RULE8
		else if (div_t && wp_r == WP_FIRST)
		begin
			p_r[1] <= v_r[31]; // RULE15
			p_r[0] <= u_r[31]; // RULE15
		end
		else if (div_t && div_odd)
			p_r[0] <= u_r[31]; // RULE16
	end

	// Odd/even flag, carry flag and quotient digits
	always_ff @(posedge aclk)
	begin
		if (!aresetn || idle)
		begin
			p1_r <= 1'b0;
			k_r <= 1'b0;
			q_r <= '0;
		end
		else if (div_t)
		begin
			if (wp_r == WP_FIRST)
				p1_r <= 1'b1; // RULE17
			else if (wp_r >= WP_ODD0 && wp_r <= WP_LAST_ODD)
				p1_r <= !p1_r; // RULE17
			if (wp_r == WP_SECTOR)
				k_r <= 1'b1; // RULE20
			if (div_odd)
				q_r <= {q_r[30:0], u_r[31]}; // RULE16
		end
	end

	// Control register and character count
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= '0;
			cnt_r <= '0;
			char_taken_r <= 1'b0;
		end
		else
		begin
			char_taken_r <= take_char;
			if (go)
				ctrl_r <= ctrl_s'(wdata[9:0]);
			if (go && wdata[1:0] == OP_INPUT)
				cnt_r <= '0;
			else if (take_char)
				cnt_r <= cnt_r + 32'h00000001;
		end
	end

	// Register bus slave
	assign wr_fire = awvalid && wvalid && !bvalid_r;
	assign rd_fire = arvalid && !rvalid_r;
	assign go = idle && wr_fire && awaddr == OFS_CTRL && wstrb[1:0] == 2'h3 && wdata[1:0] != 2'h0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= (awaddr inside {OFS_CTRL, OFS_UPPER, OFS_LOWER, OFS_INDEX, OFS_OPERAND}) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bready)
			bvalid_r <= 1'b0;
	end

	assign stat = '{chr: p_r, fgh: fgh, k: k_r, p1: p1_r, hold: a_r, m: m_r, n: n_r, busy: !idle};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= RESP_OKAY;
			unique case (araddr)
				OFS_CTRL: rdata_r <= {22'h000000, ctrl_r};
				OFS_STATUS: rdata_r <= {17'h00000, stat};
				OFS_UPPER: rdata_r <= u_r;
				OFS_LOWER: rdata_r <= l_r[31:0];
				OFS_INDEX: rdata_r <= x_r;
				OFS_OPERAND: rdata_r <= v_r;
				OFS_CHARS: rdata_r <= cnt_r;
				default:
				begin
					rdata_r <= '0;
					rresp_r <= RESP_SLVERR;
				end
			endcase
		end
		else if (rready)
			rvalid_r <= 1'b0;
	end

	assign awready = wr_fire;
	assign wready = wr_fire;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = !rvalid_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign char_taken = char_taken_r;
	assign input_call = state_r == S_EXEC && !m_r;
	assign busy = !idle;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_sector;
		state_r == S_DIV && wp_r == WP_SECTOR && sign_t;
	endsequence
	sequence s_wp1_sign;
		state_r == S_DIV && wp_r == WP_FIRST && sign_t;
	endsequence

	a_align_short: assert property (state_r == S_ALIGN && !n_r && sign_t |=> state_r == S_EXEC) // RULE1
		else $error("short line did not enter execute");
	a_align_long: assert property (state_r == S_ALIGN && n_r && !t8 |=> state_r != S_EXEC) // RULE1
		else $error("long line left alignment early");
	a_couple_char: assert property (state_r == S_EXEC && !n_r && m_r |=> u_r[31] == $past(p_r[0])) // RULE2 RULE4
		else $error("character stages not in loop");
	a_first_recirc: assert property (state_r == S_EXEC && !m_r && !n_r |=> u_r[31] == $past(l_r[0]) && !char_taken) // RULE4
		else $error("first cycle took a character");
	a_char_high: assert property (state_r == S_EXEC && ctrl_r.track_hi |=> p_r[3] == $past(p_r[4])) // RULE3
		else $error("six bit path broken");
	a_char_low: assert property (state_r == S_EXEC && !ctrl_r.track_hi |=> p_r[3] == $past(l_r[0])) // RULE6
		else $error("four bit path broken");
	a_search_recirc: assert property (state_r == S_SEARCH |=> u_r[31] == $past(u_r[0])) // RULE5
		else $error("upper not recirculating in search");
	a_long_upper: assert property (state_r == S_EXEC && n_r |=> u_r[31] == $past(u_r[0])) // RULE7
		else $error("upper not alone in long mode");
	a_stop_ends: assert property (state_r == S_SEARCH && sign_t && stop_code |=> idle && !a_r) // RULE9
		else $error("stop did not end input");
	a_swap_lower: assert property (state_r == S_SWAP && !n_r && ctrl_r.trk[0] |=> l_r[31] == $past(u_r[0])) // RULE10
		else $error("upper not copied to lower");
	a_swap_repeat: assert property (state_r == S_SWAP && ctrl_r.rpt |=> x_r[31] == $past(x_r[0])) // RULE12
		else $error("index changed on repeat");
	a_swap_length: assert property (state_r == S_SWAP && sign_t && ctrl_r.trk[4] && !ctrl_r.trk[5] |=> n_r) // RULE13
		else $error("length not set long");
	a_div_signs: assert property (s_wp1_sign |=> p_r[1] == $past(v_r[31]) ##32 p_r[1] == $past(v_r[31], 33)) // RULE15
		else $error("divisor sign not held");
	a_toggle_odd: assert property (s_wp1_sign |=> p1_r ##64 !p1_r) // RULE17
		else $error("odd/even flag wrong at period 3");
	a_sector_end: assert property (s_sector |=> k_r ##96 idle) // RULE20
		else $error("three closing periods not run");
	a_quot_pos: assert property (state_r == S_DIV && wp_r == WP_QUOT && sign_t && !p_r[1]
		|=> u_r == {$past(q_r[31]), ~$past(q_r[30:0])}) // RULE22
		else $error("quotient not complemented");
endmodule
`default_nettype wire

// ==== testbench/io_unit_model.sv ====
// Character source standing in for the input/output unit
`default_nettype none
module io_unit_model
	import sacc_pkg::*;
(
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset
	input wire logic input_call, // Input wanted
	input wire logic char_taken, // Character accepted
	input wire logic busy, // Command running
	output logic char_valid, // Character present
	output logic [5:0] char_data, // Character
	output logic stop_code // Stop code
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] chars[16];
	int count = 0;
	int idx = 0;
	int gap = 0;
	int wait_n = 0;
	logic use_stop = 1'b1;
	logic called = 1'b0;
	task automatic load(input int n, input int g, input logic s);
		count = n;
		gap = g;
		use_stop = s;
		idx = 0;
		wait_n = g;
	endtask
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			char_valid <= 1'b0;
			char_data <= 6'h3f;
			stop_code <= 1'b0;
			called <= 1'b0;
		end
		else if (called && !busy)
		begin
			called <= 1'b0;
			stop_code <= 1'b0;
		end
		else if (input_call)
			called <= 1'b1;
		else if (char_valid && char_taken)
		begin
			// Released line shows inverse of last character
			char_valid <= 1'b0;
			char_data <= ~char_data;
			idx <= idx + 1;
			wait_n <= gap;
		end
		else if (called && !char_valid)
		begin
			if (wait_n > 0)
				wait_n <= wait_n - 1;
			else if (idx < count)
			begin
				char_valid <= 1'b1;
				char_data <= chars[idx];
			end
			else if (use_stop)
				stop_code <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the serial accumulator block
`default_nettype none
module tb_top
	import sacc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic go_sw = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rd;
	logic char_valid, char_taken, stop_code, input_call, busy;
	logic [5:0] char_data;
	int bad_count = 0;
	int checked = 0;
	int busy_n = 0;
	int call_n = 0;
	int call_at = 0;
	serial_accumulator_exec dut_u (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .char_valid, .char_data, .char_taken, .stop_code,
		.operator_go_switch(go_sw), .input_call, .busy);
	io_unit_model io_u (.aclk, .aresetn, .input_call, .char_taken, .busy, .char_valid, .char_data,
		.stop_code);
	always #5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		if (busy === 1'b1)
			busy_n <= busy_n + 1;
		if (input_call === 1'b1)
		begin
			if (call_n == 0)
				call_at <= busy_n;
			call_n <= call_n + 1;
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wait_for(ref logic s, input logic v, input int lim, input string w);
		for (int n = 0; n < lim; n++)
		begin
			@(posedge aclk);
			if (s === v)
				return;
		end
		bad_count++;
		$display("wrong value at %0t: %s timed out", $time, w);
		conclude();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		wait_for(awready, 1'b1, 50, "aw");
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		wait_for(bvalid, 1'b1, 50, "b");
		bready <= 1'b0;
		check(bresp, er, "bresp");
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		wait_for(arready, 1'b1, 50, "ar");
		arvalid <= 1'b0;
		wait_for(rvalid, 1'b1, 50, "r");
		rd = rdata;
		rready <= 1'b0;
		check(rresp, er, "rresp");
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		rd_reg(a, RESP_OKAY);
		check(rd, exp, what);
	endtask
	task automatic set3(input logic [31:0] u, input logic [31:0] l, input logic [31:0] x);
		wr(OFS_UPPER, u, RESP_OKAY);
		wr(OFS_LOWER, l, RESP_OKAY);
		wr(OFS_INDEX, x, RESP_OKAY);
	endtask
	function automatic logic [31:0] ctl(input logic hi, input logic [5:0] t, input logic r, input logic [1:0] o);
		return {22'h0, ctrl_s'{hi, t, r, o}};
	endfunction
	task automatic run(input logic [31:0] c, input int lim);
		busy_n = 0;
		wr(OFS_CTRL, c, RESP_OKAY);
		wait_for(busy, 1'b0, lim, "busy");
	endtask
	task automatic t_map();
		rdchk(OFS_STATUS, 32'h0, "status");
		rdchk(OFS_CHARS, 32'h0, "chars");
		rd_reg(8'h1c, RESP_SLVERR);
		check(rd, 32'h0, "unmapped");
		wr(OFS_STATUS, 32'hffff_ffff, RESP_SLVERR);
		wr(OFS_CHARS, 32'h5, RESP_SLVERR);
		rdchk(OFS_STATUS, 32'h0, "status ro");
		wr(OFS_UPPER, 32'h1234_5678, RESP_OKAY);
		rdchk(OFS_UPPER, 32'h1234_5678, "upper rw");
		$display("map test done");
	endtask
	task automatic t_swap();
		set3(32'ha5a5_0f0f, 32'h0000_ff00, 32'h1111_0001);
		run(ctl(0, 6'h01, 0, OP_SWAP), 100);
		check(busy_n, 32, "swap len");
		rdchk(OFS_LOWER, 32'ha5a5_0f0f, "L from U");
		rdchk(OFS_UPPER, 32'ha5a5_0f0f, "U kept");
		set3(32'h0, 32'h0000_ff00, 32'h1111_0001);
		run(ctl(0, 6'h0a, 0, OP_SWAP), 100);
		rdchk(OFS_UPPER, 32'h1111_ff01, "U from L or X");
		rdchk(OFS_LOWER, 32'h0000_ff00, "L kept");
		run(ctl(0, 6'h04, 1, OP_SWAP), 100);
		rdchk(OFS_INDEX, 32'h1111_0001, "X on repeat");
		run(ctl(0, 6'h04, 0, OP_SWAP), 100);
		rdchk(OFS_INDEX, 32'h1111_ff01, "X from U");
		// Long, short, toggle to long, toggle back
		for (int i = 0; i < 4; i++)
		begin
			run(ctl(0, i == 0 ? 6'h10 : (i == 1 ? 6'h20 : 6'h30), 0, OP_SWAP), 100);
			rd_reg(OFS_STATUS, RESP_OKAY);
			check(rd[1], !i[0], "length");
		end
		$display("swap test done");
	endtask
	task automatic t_div();
		// Quarter over half, then over minus half
		for (int i = 0; i < 2; i++)
		begin
			set3(32'h2000_0000, 32'h0, 32'h0000_0077);
			wr(OFS_OPERAND, i == 0 ? 32'h4000_0000 : 32'hc000_0000, RESP_OKAY);
			busy_n = 0;
			wr(OFS_CTRL, ctl(0, 6'h0, 0, OP_DIV), RESP_OKAY);
			wr(OFS_INDEX, 32'hdead_0000, RESP_OKAY);
			wait_for(busy, 1'b0, 3000, "divide");
			check(busy_n, 2144, "divide len");
			rdchk(OFS_INDEX, 32'h77, "X held");
			rdchk(OFS_UPPER, i == 0 ? 32'h4000_0000 : 32'hc000_0000, "quotient");
			rdchk(OFS_LOWER, 32'h0, "remainder");
		end
		$display("divide test done");
	endtask
	task automatic t_in(input logic hi, input int n, input logic s, input int gap, input logic lng);
		logic [63:0] acc;
		int k;
		acc = {32'h0f0f_0f0f, 32'h3};
		if (lng)
			run(ctl(0, 6'h10, 0, OP_SWAP), 100);
		wr(OFS_UPPER, acc[63:32], RESP_OKAY);
		wr(OFS_LOWER, acc[31:0], RESP_OKAY);
		for (k = 0; k < n; k++)
		begin
			io_u.chars[k] = 6'(k * 13 + 7);
			acc = hi ? {acc[57:0], io_u.chars[k]} : {acc[59:0], io_u.chars[k][3:0]};
		end
		io_u.load(n, gap, s);
		call_n = 0;
		busy_n = 0;
		wr(OFS_CTRL, ctl(hi, 6'h0, 0, OP_INPUT), RESP_OKAY);
		if (!s)
		begin
			for (k = 0; k < 30000 && io_u.idx < n; k++)
				@(posedge aclk);
			// Switch is only heard in search, after the last execute
			repeat (200) @(posedge aclk);
			rd = 32'h0;
			for (k = 0; k < 300 && rd[3] !== 1'b1; k++)
				rd_reg(OFS_STATUS, RESP_OKAY);
			go_sw <= 1'b1;
		end
		wait_for(busy, 1'b0, 30000, "input");
		go_sw <= 1'b0;
		check(call_n, lng ? 256 : 64, "call len");
		if (!lng)
			check(call_at, 32, "call start");
		rdchk(OFS_LOWER, acc[31:0], "lower");
		rdchk(OFS_UPPER, lng ? 32'h0f0f_0f0f : acc[63:32], "upper");
		rdchk(OFS_CHARS, n, "count");
		rd_reg(OFS_STATUS, RESP_OKAY);
		check(rd[3], 1'b0, "hold");
		if (lng)
			run(ctl(0, 6'h20, 0, OP_SWAP), 100);
		$display("input test done");
	endtask
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_map();
		t_swap();
		t_div();
		t_in(1'b0, 3, 1'b1, 0, 1'b0);
		t_in(1'b1, 12, 1'b0, 5, 1'b0);
		t_in(1'b0, 3, 1'b1, 2, 1'b1);
		conclude();
	end
endmodule
`default_nettype wire
